// ---- sccap_pkg.sv ----
// Purpose: Shared constants and types for the secondary clock control and
//          subsystem capability register block.
// Assumes: Byte addressing on a 32-bit Avalon-MM slave, one register per word.
// Notes:   Identity values are module parameters, not constants here.
`default_nettype none

package sccap_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] SCCAP_OFS_CLK_CTRL = 8'hA4;
  localparam logic [7:0] SCCAP_OFS_CAP_HDR = 8'hA8;
  localparam logic [7:0] SCCAP_OFS_CARD_ID = 8'hAC;

  // ************************************************************
  // Clock control field positions
  // ************************************************************
  localparam int SCCAP_SLOT_FIELD_W = 2;
  localparam int SCCAP_POS_STOP_STATUS = 13;
  localparam int SCCAP_POS_CLKRUN_EN = 14;
  localparam int SCCAP_POS_CLKRUN_MODE = 15;
  localparam int SCCAP_POS_L0S_IDLE_ONLY = 16;
  localparam int SCCAP_POS_SCRAMBLE_LO = 17;
  localparam int SCCAP_SCRAMBLE_W = 2;

  // ************************************************************
  // Codes and reset values
  // ************************************************************
  localparam logic [1:0] SCCAP_SLOT_CODE_OFF = 2'h3;
  localparam logic [7:0] SCCAP_SLOT_CODES_RST = 8'h00;
  localparam logic SCCAP_CLKRUN_EN_RST = 1'b0;
  localparam logic SCCAP_CLKRUN_MODE_RST = 1'b0;
  localparam logic SCCAP_L0S_IDLE_ONLY_RST = 1'b1;
  localparam logic [1:0] SCCAP_SCRAMBLE_RST = 2'h0;
  localparam logic [7:0] SCCAP_CAP_ID = 8'h0D;
  localparam logic [7:0] SCCAP_NEXT_PCIE = 8'hB0;
  localparam logic [7:0] SCCAP_NEXT_SLOT_ID = 8'hA0;

  // ************************************************************
  // Bus answer states
  // ************************************************************
  typedef enum logic [1:0] {
    SCCAP_ST_IDLE = 2'b01,
    SCCAP_ST_ACK = 2'b10
  } sccap_bus_st_t;

endpackage

`default_nettype wire

// ---- sccap_top.sv ----
// Purpose: Secondary slot clock gating, clock-run stop policy, L0s entry
//          policy and the card_identifier capability item, behind Avalon-MM.
// Assumes: clk at 200 MHz; sec_clk is the secondary bus clock source.
// Notes:   Slot clocks run at half the sec_clk rate and come from flops.
//
// Behaviour
// - Slot 0 clock field bits 1:0; code 11 stops clock low, reset 00.
// - Slot 1 clock field bits 3:2; code 11 stops clock low, reset 00.
// - Slot 2 clock field bits 5:4; code 11 stops clock low, reset 00.
// - Slot 3 clock field bits 7:6; code 11 stops clock low, reset 00.
// - Bit 13 reads 1 while secondary clock is stopped, else 0.
// - Bit 14 enables the clock-run protocol; resets to 0.
// - Bit 15: 0 stops only in D3hot; 1 stops when idle, nothing pending.
// - Bit 16 set limits L0s entry to receiver electrical idle; resets 1.
// - Subsys_cap_identifier byte of the second item reads 0Dh.
// - Next pointer is B0h, or A0h when slot identification is loaded.
// - Read-only subsystem vendor identifier in bits 15:0 of next word.
// - Read-only subsystem identifier in bits 31:16 of that word.
//
// Design decision made here: the Avalon-MM register port.
`default_nettype none

module sccap_top
  import sccap_pkg::*;
#(
  parameter logic [15:0] CARD_VENDOR_ID = 16'h5A3C, // Arbitrary value.
  parameter logic [15:0] CARD_ID = 16'h1E27 // Arbitrary value.
) (
  // Clocks and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sec_clk,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Power and link signals to and from the bridge core
  input wire logic in_d3hot,
  input wire logic primary_req_pending,
  input wire logic slot_ident_enable,
  input wire logic l0s_request,
  output logic l0s_enter,
  output logic [1:0] scramble_ctrl,
  // Pins
  input wire logic sec_bus_idle,
  input wire logic rx_elec_idle,
  output logic slot0_clock_output,
  output logic slot1_clock_output,
  output logic slot2_clock_output,
  output logic slot3_clock_output
);

  localparam int SLOTS = 4;

  // Every slot field must sit below the reserved span that starts at bit 8.
  if (SCCAP_SLOT_FIELD_W * SLOTS != 8) begin : g_slot_map_check
    $error("slot fields do not fill bits 7:0 of the control word");
  end

  // ************************************************************
  // Register-side state
  // ************************************************************
  typedef struct packed {
    sccap_bus_st_t st;
    logic [31:0] rdata;
    logic [2*SLOTS-1:0] slot_codes;
    logic clkrun_en;
    logic clkrun_mode;
    logic l0s_idle_only;
    logic [1:0] scramble;
    logic idle_s1;
    logic idle_s2;
    logic eidle_s1;
    logic eidle_s2;
    logic stopped_s1;
    logic stopped_s2;
    logic stop_req;
  } sccap_reg_t;

  // ************************************************************
  // Secondary clock side state
  // ************************************************************
  typedef struct packed {
    logic stop_s1;
    logic stop_s2;
    logic [SLOTS-1:0] en_s1;
    logic [SLOTS-1:0] en_s2;
    logic phase;
    logic [SLOTS-1:0] slot_clk;
  } sccap_sec_t;

  sccap_reg_t r;
  sccap_reg_t next_r;
  sccap_sec_t s;
  sccap_sec_t next_s;

  // Codes 00, 01 and 10 all run the clock; only 11 stops it.
  function automatic logic slot_on(input logic [1:0] code);
    slot_on = (code != SCCAP_SLOT_CODE_OFF);
  endfunction

  function automatic logic [31:0] ctrl_word(input sccap_reg_t v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[2*SLOTS-1:0] = v.slot_codes;
    w[SCCAP_POS_STOP_STATUS] = v.stopped_s2;
    w[SCCAP_POS_CLKRUN_EN] = v.clkrun_en;
    w[SCCAP_POS_CLKRUN_MODE] = v.clkrun_mode;
    w[SCCAP_POS_L0S_IDLE_ONLY] = v.l0s_idle_only;
    w[SCCAP_POS_SCRAMBLE_LO +: SCCAP_SCRAMBLE_W] = v.scramble;
    ctrl_word = w;
  endfunction

  // ************************************************************
  // Register-side logic
  // ************************************************************
  always_comb begin
    logic [31:0] cur;
    logic [31:0] upd;
    logic [7:0] next_ptr;
    cur = ctrl_word(r);
    upd = cur;
    next_ptr = slot_ident_enable ? SCCAP_NEXT_SLOT_ID : SCCAP_NEXT_PCIE;
    next_r = r;
    next_r.idle_s1 = sec_bus_idle;
    next_r.idle_s2 = r.idle_s1;
    next_r.eidle_s1 = rx_elec_idle;
    next_r.eidle_s2 = r.eidle_s1;
    next_r.stopped_s1 = s.stop_s2;
    next_r.stopped_s2 = r.stopped_s1;
    // Stopping never happens with the protocol off, whatever the mode says.
    if (!r.clkrun_en) begin
      next_r.stop_req = 1'b0;
    end else if (r.clkrun_mode) begin
      next_r.stop_req = r.idle_s2 && !primary_req_pending;
    end else begin
      next_r.stop_req = in_d3hot;
    end
    for (int b = 0; b < 4; b++) begin
      if (byteenable[b]) begin
        upd[8*b +: 8] = writedata[8*b +: 8];
      end
    end
    unique case (r.st)
      SCCAP_ST_IDLE: begin
        if (read || write) begin
          next_r.st = SCCAP_ST_ACK;
          next_r.rdata = 32'h0000_0000;
          if (read) begin
            unique case (address)
              SCCAP_OFS_CLK_CTRL: next_r.rdata = cur;
              SCCAP_OFS_CAP_HDR: next_r.rdata = {16'h0000, next_ptr, SCCAP_CAP_ID};
              SCCAP_OFS_CARD_ID: next_r.rdata = {CARD_ID, CARD_VENDOR_ID};
              default: next_r.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
      SCCAP_ST_ACK: begin
        next_r.st = SCCAP_ST_IDLE;
        // Writes land on the edge where waitrequest is seen low.
        if (write && address == SCCAP_OFS_CLK_CTRL) begin
          next_r.slot_codes = upd[2*SLOTS-1:0];
          next_r.clkrun_en = upd[SCCAP_POS_CLKRUN_EN];
          next_r.clkrun_mode = upd[SCCAP_POS_CLKRUN_MODE];
          next_r.l0s_idle_only = upd[SCCAP_POS_L0S_IDLE_ONLY];
          next_r.scramble = upd[SCCAP_POS_SCRAMBLE_LO +: SCCAP_SCRAMBLE_W];
        end
      end
      default: next_r.st = SCCAP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{st: SCCAP_ST_IDLE, rdata: 32'h0000_0000, slot_codes: SCCAP_SLOT_CODES_RST,
             clkrun_en: SCCAP_CLKRUN_EN_RST, clkrun_mode: SCCAP_CLKRUN_MODE_RST,
             l0s_idle_only: SCCAP_L0S_IDLE_ONLY_RST, scramble: SCCAP_SCRAMBLE_RST,
             default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign waitrequest = (r.st != SCCAP_ST_ACK);
  assign readdata = r.rdata;
  assign scramble_ctrl = r.scramble;
  assign l0s_enter = l0s_request && (!r.l0s_idle_only || r.eidle_s2);

  // ************************************************************
  // Secondary clock side logic
  // ************************************************************
  // Each slot enable crosses as an independent quasi-static level; a slot
  // may change a sec_clk cycle before its neighbour after one write.
  always_comb begin
    next_s = s;
    next_s.stop_s1 = r.stop_req;
    next_s.stop_s2 = s.stop_s1;
    next_s.phase = !s.phase;
    for (int i = 0; i < SLOTS; i++) begin
      next_s.en_s1[i] = slot_on(r.slot_codes[2*i +: 2]);
      next_s.en_s2[i] = s.en_s1[i];
      // Gated slots and a stopped clock hold the output low.
      next_s.slot_clk[i] = s.en_s2[i] && !s.stop_s2 && !s.phase;
    end
  end

  always_ff @(posedge sec_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign slot0_clock_output = s.slot_clk[0];
  assign slot1_clock_output = s.slot_clk[1];
  assign slot2_clock_output = s.slot_clk[2];
  assign slot3_clock_output = s.slot_clk[3];

endmodule

`default_nettype wire

// ---- sccap_asserts.sv ----
// Purpose: Bus timing and fixed read values of the register block.
// Assumes: All checks live in the clk domain.
// Notes: Read data are judged in the cycle after the take edge.
`default_nettype none
module sccap_asserts
  import sccap_pkg::*;
#(
  parameter logic [15:0] CARD_VENDOR_ID = 16'h5A3C,
  parameter logic [15:0] CARD_ID = 16'h1E27
) (
  // Clock and bus
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Status
  input wire logic slot_ident_enable,
  input wire logic l0s_request,
  input wire logic l0s_enter,
  input wire logic rx_elec_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence rd_take(logic [7:0] a);
    read && waitrequest && address == a;
  endsequence
  a_ack_next: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered next cycle");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  a_l0s_gate: assert property (l0s_enter |-> l0s_request)
    else $error("l0s entry without request");
  a_l0s_idle: assert property (l0s_request && $past(rst_b, 2) && $past(rx_elec_idle, 2)
    |-> l0s_enter) else $error("l0s entry held off in receiver idle");
  a_cap_ident: assert property (rd_take(SCCAP_OFS_CAP_HDR) |=> readdata[7:0] == 8'h0D)
    else $error("bad subsys_cap_identifier");
  a_next_link: assert property (rd_take(SCCAP_OFS_CAP_HDR) |=>
    readdata[15:8] == ($past(slot_ident_enable) ? 8'hA0 : 8'hB0)) else $error("bad next link");
  a_card_ids: assert property (rd_take(SCCAP_OFS_CARD_ID) |=>
    readdata == {CARD_ID, CARD_VENDOR_ID}) else $error("bad card ids");
  a_rsvd_zero: assert property (rd_take(SCCAP_OFS_CLK_CTRL) |=>
    readdata[12:8] == 5'h00 && readdata[31:19] == 13'h0000) else $error("reserved bits set");
  a_hdr_upper: assert property (rd_take(SCCAP_OFS_CAP_HDR) |=> readdata[31:16] == 16'h0000)
    else $error("header upper half set");
endmodule
`default_nettype wire

// ---- sccap_card_model.sv ----
// Purpose: Cards on the secondary bus; they watch the slot clocks.
// Assumes: Slot clocks toggle on every rising sec_clk edge while running.
// Notes: active shows which slot toggled over the last edge.
`default_nettype none
module sccap_card_model (
  // Secondary bus
  input wire logic sec_clk,
  input wire logic [3:0] slot_clk,
  input wire logic busy,
  output logic sec_bus_idle,
  output logic [3:0] active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last;
  assign sec_bus_idle = !busy;
  always @(posedge sec_clk) begin
    last <= slot_clk;
    active <= slot_clk ^ last;
  end
endmodule
`default_nettype wire

// ---- sccap_top_tb.sv ----
// Purpose: Self-checking bench for the slot clock and capability block.
// Assumes: Avalon answers are awaited, never counted on.
// Notes: Stop status crosses domains, so checks wait a dozen sec_clk edges.
`default_nettype none
module sccap_top_tb;
  import sccap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} sccap_row_t;
  logic clk = 0, sec_clk, rst_b, read, write, waitrequest, l0s_enter, busy, idle;
  logic in_d3hot, primary_req_pending, slot_ident_enable, l0s_request, rx_elec_idle;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic [1:0] scramble_ctrl;
  wire [3:0] slot;
  logic [3:0] active;
  int errors, samples_checked;
  sccap_row_t rows [4] = '{'{8'hA4, 32'hFFFFBFFF, 32'h000780FF},
    '{8'hA8, 32'hFFFFFFFF, 32'h0000B00D}, '{8'hAC, 32'h00000000, 32'h1E275A3C},
    '{8'h40, 32'hFFFFFFFF, 32'h00000000}};
  always #2.5 clk = ~clk;
  initial begin
    sec_clk = 0;
    #3;
    forever #16 sec_clk = ~sec_clk;
  end
  sccap_top i_sccap_top (.clk(clk), .rst_b(rst_b), .sec_clk(sec_clk), .address(address),
    .read(read), .write(write), .byteenable(4'hF), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .in_d3hot(in_d3hot),
    .primary_req_pending(primary_req_pending), .slot_ident_enable(slot_ident_enable),
    .l0s_request(l0s_request), .l0s_enter(l0s_enter), .scramble_ctrl(scramble_ctrl),
    .sec_bus_idle(idle), .rx_elec_idle(rx_elec_idle), .slot0_clock_output(slot[0]),
    .slot1_clock_output(slot[1]), .slot2_clock_output(slot[2]), .slot3_clock_output(slot[3]));
  sccap_card_model i_sccap_card_model (.sec_clk(sec_clk), .slot_clk(slot), .busy(busy),
    .sec_bus_idle(idle), .active(active));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    // A low waitrequest or the watchdog ends this wait; the answer edge is awaited, not counted.
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic settle;
    repeat (12) @(posedge sec_clk);
    @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #50000;
    errors++;
    print_verdict;
  end
  initial begin
    {read, write, in_d3hot, primary_req_pending, slot_ident_enable, busy} = '0;
    {l0s_request, rx_elec_idle, rst_b, address, writedata} = '0;
    errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1;
    l0s_request <= 1;
    bus(0, 8'hA4, 0);
    check(q, 32'h00010000);
    check(l0s_enter, 0);
    rx_elec_idle <= 1;
    settle;
    check(l0s_enter, 1);
    rx_elec_idle <= 0;
    foreach (rows[i]) begin
      bus(1, rows[i].a, rows[i].d);
      bus(0, rows[i].a, 0);
      check(q, rows[i].e);
    end
    check(scramble_ctrl, 2'h3);
    bus(1, 8'hA4, 32'h000000E4);
    settle;
    check(active, 4'b0111);
    check(l0s_enter, 1);
    bus(1, 8'hA4, 32'h0000001B);
    settle;
    check(active, 4'b1110);
    in_d3hot <= 1;
    bus(1, 8'hA4, 32'h00004000);
    settle;
    bus(0, 8'hA4, 0);
    check(q, 32'h00006000);
    check(active, 4'h0);
    in_d3hot <= 0;
    bus(1, 8'hA4, 32'h0000C000);
    settle;
    bus(0, 8'hA4, 0);
    check(q, 32'h0000E000);
    primary_req_pending <= 1;
    settle;
    bus(0, 8'hA4, 0);
    check(q, 32'h0000C000);
    check(active, 4'hF);
    primary_req_pending <= 1'b0;
    busy <= 1'b1;
    settle;
    bus(0, 8'hA4, 0);
    check(q, 32'h0000C000);
    check(active, 4'hF);
    busy <= 1'b0;
    slot_ident_enable <= 1;
    bus(0, 8'hA8, 0);
    check(q, 32'h0000A00D);
    rst_b <= 1'b0;
    repeat (2) @(posedge sec_clk);
    @(posedge clk);
    rst_b <= 1'b1;
    bus(0, 8'hA4, 0);
    check(q, 32'h00010000);
    settle;
    check(active, 4'hF);
    print_verdict;
  end
endmodule
bind sccap_top sccap_asserts #(.CARD_VENDOR_ID(CARD_VENDOR_ID), .CARD_ID(CARD_ID))
  i_sccap_asserts (.clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .slot_ident_enable(slot_ident_enable),
  .l0s_request(l0s_request), .l0s_enter(l0s_enter), .rx_elec_idle(rx_elec_idle));
`default_nettype wire
